// ### panel_operator.sv
// Front-panel operator model that presses the four switches.
`timescale 1ns/1ps
module panel_operator (
	// Clock.
	input  wire logic CLOCK,
	// Switches, high while pressed.
	output logic      SW_SET,
	output logic      SW_UP,
	output logic      SW_DOWN,
	output logic      SW_ESC
);
	logic [3:0] sw_reg;
	assign {SW_ESC, SW_DOWN, SW_UP, SW_SET} = sw_reg;
	initial sw_reg = 4'h0;
	// Press switch k (0 set, 1 up, 2 down, 3 esc) for a number of edges.
	task automatic press(input int k, input int hold);
		@(posedge CLOCK);
		sw_reg[k] <= 1'b1;
		repeat (hold) @(posedge CLOCK);
		sw_reg <= 4'h0;
		repeat (3) @(posedge CLOCK);
	endtask
	// Up and down held together across power-up ask for factory values.
	task automatic restore(input logic on);
		sw_reg <= {1'b0, on, on, 1'b0};
	endtask
endmodule

// ### settings_store.v
// Non-volatile settings store: one write port, registered read data.
`timescale 1ns/1ps
module settings_store #(
	parameter AW = 4,
	parameter DW = 8
) (
	// Clock, reset and clock enable.
	input  wire          clk,
	input  wire          rst_n,
	input  wire          ce,
	// Write port.
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [DW-1:0] wdata,
	// Read port.
	input  wire [AW-1:0] raddr,
	output reg  [DW-1:0] rdata
);

// The array has no reset, so its contents outlive a reset of the logic.
reg [DW-1:0] mem [0:(1<<AW)-1];

always @(posedge clk) begin
	if (ce && we) begin
		mem[waddr] <= wdata;
	end
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		rdata <= {DW{1'b0}};
	end else if (ce) begin
		rdata <= mem[raddr];
	end
end

endmodule

// ### test_timecode_parameter_menu.sv
// Self-checking testbench for the front-panel parameter menu.
`timescale 1ns/1ps
module test_timecode_parameter_menu;
	logic        clk, rstn, ce, psel, penable, pwrite, err;
	logic        tc_present, frame_tick, tc_gen, ltc_idle;
	logic        sw_set, sw_up, sw_down, sw_esc, pready, pslverr;
	logic        vitc_ins, found, overlay, regen, hold, mtc_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] pair_valid;
	logic [1:0]  menu_state, tach_dir;
	logic        sd_pal, sibling, legacy;
	logic [3:0]  menu_item, read_pair;
	logic [7:0]  disp, gen_line, fw_left, level, ppf;
	logic [2:0]  gain;
	logic [4:0]  hd_rate;
	logic [7:0]  dflt [15];
	int          num_errors, checked, n;

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	timecode_parameter_menu dut (.CLOCK(clk), .RESETN(rstn), .CE(ce),
		.SW_SET(sw_set), .SW_UP(sw_up), .SW_DOWN(sw_down), .SW_ESC(sw_esc),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .VITC_PAIR_VALID(pair_valid),
		.TC_PRESENT(tc_present), .FRAME_TICK(frame_tick),
		.TC_GENERATING(tc_gen), .LTC_IDLE(ltc_idle),
		.MENU_STATE(menu_state), .MENU_ITEM(menu_item), .DISP_VALUE(disp),
		.VITC_INSERT_EN(vitc_ins), .VITC_READ_PAIR(read_pair),
		.VITC_READ_FOUND(found), .VITC_GEN_LINE(gen_line),
		.OVERLAY_ENABLE(overlay), .TC_REGEN(regen),
		.FREEWHEEL_LEFT(fw_left), .LTC_LEVEL_DBU(level),
		.RESOLVE_GAIN(gain), .RATE_HOLD(hold), .TACH_PPF(ppf),
		.TACH_DIRECTION(tach_dir), .SD_FORMAT_PAL(sd_pal),
		.HD_RATE(hd_rate), .MTC_ENABLE(mtc_en),
		.SIBLING_IDENTITY(sibling), .LEGACY_EMULATION(legacy));
	panel_operator op (.CLOCK(clk), .SW_SET(sw_set), .SW_UP(sw_up),
		.SW_DOWN(sw_down), .SW_ESC(sw_esc));
	//////////////////////////////////////////////////////////////////////
	task automatic test_done;
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 200);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 200) begin
			num_errors++;
			test_done();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] v,
		input logic e);
		apb(1'b1, a, {24'h0, v});
		chk(err, e);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [7:0] v);
		apb(1'b0, a, 32'h0);
		chk(rd, {24'h0, v});
	endtask
	task automatic do_reset(input logic r);
		rstn <= 1'b0;
		op.restore(r);
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		op.restore(1'b0);
		for (n = 0; n < 100 && menu_state !== 2'd1; n++) cyc(1);
		chk(menu_state, 2'd1);
		if (menu_state !== 2'd1)
			test_done();
		cyc(2);
	endtask
	task automatic tick;
		frame_tick <= 1'b1;
		cyc(1);
		frame_tick <= 1'b0;
	endtask
	task automatic t_defaults;
		for (int i = 0; i < 15; i++)
			rdchk(12'h040 + 12'(4 * i), dflt[i]);
		chk(level, 8'h03);
		chk(gen_line, 8'h0e);
		chk(ppf, 8'h64);
		chk({vitc_ins, overlay, hold}, 3'b110);
	endtask
	task automatic t_panel;
		op.press(0, 1);
		chk(menu_state, 2'd2);
		for (n = 0; n < 20 && menu_item !== 4'h6; n++) op.press(2, 1);
		chk(menu_item, 4'h6);
		if (menu_item !== 4'h6)
			test_done();
		op.press(0, 6);
		chk({menu_state, disp}, 10'h300);
		op.press(2, 1);
		chk(disp, 8'hfc);
		op.press(0, 1);
		cyc(2);
		chk({menu_state, gain}, 5'h14);
		rdchk(12'h058, 8'h04);
		op.press(0, 1);
		op.press(1, 1);
		chk(disp, 8'h00);
		op.press(3, 1);
		chk({menu_state, gain}, 5'h14);
		op.press(3, 1);
		chk(menu_state, 2'd1);
	endtask
	task automatic t_apb;
		wr(12'h054, 8'h22, 1'b1);
		wr(12'h054, 8'h21, 1'b0);
		cyc(2);
		chk(level, 8'h09);
		wr(12'h054, 8'h00, 1'b0);
		cyc(2);
		chk(level, 8'he8);
		wr(12'h058, 8'h05, 1'b1);
		wr(12'h06c, 8'h17, 1'b1);
	endtask
	task automatic t_vitc;
		pair_valid <= 16'h0030;
		cyc(3);
		chk({found, read_pair}, 5'h14);
		wr(12'h044, 8'h03, 1'b0);
		cyc(2);
		chk(read_pair, 4'h2);
		pair_valid <= 16'h0000;
		wr(12'h044, 8'h00, 1'b0);
		cyc(3);
		chk(found, 1'b0);
	endtask
	task automatic t_fw_mtc;
		wr(12'h050, 8'h02, 1'b0);
		tc_present <= 1'b1;
		cyc(3);
		tc_present <= 1'b0;
		cyc(3);
		chk({regen, fw_left}, 9'h102);
		tick();
		cyc(2);
		chk(regen, 1'b1);
		tick();
		cyc(3);
		chk(regen, 1'b0);
		tc_gen <= 1'b1;
		ltc_idle <= 1'b1;
		cyc(3);
		chk(mtc_en, 1'b0);
		wr(12'h070, 8'h00, 1'b0);
		cyc(3);
		chk(mtc_en, 1'b1);
		ltc_idle <= 1'b0;
	endtask
	task automatic t_misc;
		wr(12'h064, 8'h02, 1'b0);
		wr(12'h068, 8'h01, 1'b0);
		wr(12'h074, 8'h01, 1'b0);
		wr(12'h078, 8'h01, 1'b0);
		wr(12'h048, 8'h0b, 1'b1);
		wr(12'h000, 8'h00, 1'b1);
		cyc(2);
		chk({tach_dir, sd_pal, sibling, legacy}, 5'h17);
		chk(gen_line, 8'h0e);
		ce <= 1'b0;
		op.press(0, 1);
		chk(menu_state, 2'd1);
		ce <= 1'b1;
		cyc(2);
		chk(menu_state, 2'd1);
	endtask
	task automatic t_nv;
		wr(12'h048, 8'h14, 1'b0);
		wr(12'h06c, 8'h16, 1'b0);
		wr(12'h05c, 8'h01, 1'b0);
		do_reset(1'b0);
		rdchk(12'h048, 8'h14);
		rdchk(12'h06c, 8'h16);
		rdchk(12'h054, 8'h1b);
		rdchk(12'h070, 8'h01);
		chk({gen_line, hd_rate, hold}, 14'h052d);
	endtask
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		{psel, penable, pwrite, tc_present, frame_tick} = 5'h0;
		{tc_gen, ltc_idle, paddr, pwdata, pair_valid} = '0;
		dflt = '{8'h01, 8'h00, 8'h0e, 8'h01, 8'h08, 8'h1b, 8'h00,
			8'h00, 8'h64, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
		do_reset(1'b1);
		t_defaults();
		t_panel();
		t_apb();
		t_vitc();
		t_fw_mtc();
		t_misc();
		t_nv();
		test_done();
	end
endmodule

// ### timecode_menu_checker.sv
// Assertion checker for the front-panel parameter menu.
`timescale 1ns/1ps
module timecode_menu_checker (
	// Clock and control.
	input wire logic       CLOCK,
	input wire logic       RESETN,
	input wire logic       CE,
	// Status inputs.
	input wire logic       TC_PRESENT,
	input wire logic       TC_GENERATING,
	input wire logic       LTC_IDLE,
	// Outputs watched.
	input wire logic       PSLVERR,
	input wire logic [1:0] MENU_STATE,
	input wire logic [3:0] MENU_ITEM,
	input wire logic       TC_REGEN,
	input wire logic       MTC_ENABLE,
	input wire logic [7:0] VITC_GEN_LINE,
	input wire logic [7:0] LTC_LEVEL_DBU,
	input wire logic [2:0] RESOLVE_GAIN,
	input wire logic [4:0] HD_RATE
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESETN);
	//////////////////////////////////////////////////////////////////////
	property p_gen_line;
		VITC_GEN_LINE == 8'h00 || (VITC_GEN_LINE >= 8'h0a
			&& VITC_GEN_LINE <= 8'h14 && !VITC_GEN_LINE[0]);
	endproperty
	a_gen_line: assert property (p_gen_line)
		else $error("generate line outside its list");
	// The offset maps -24..+9 dBu onto 0..33 with 8-bit wrap.
	property p_level;
		8'(LTC_LEVEL_DBU + 8'h18) <= 8'h21;
	endproperty
	a_level: assert property (p_level)
		else $error("output level out of range");
	property p_gain;
		RESOLVE_GAIN <= 3'h4;
	endproperty
	a_gain: assert property (p_gain)
		else $error("servo gain out of range");
	property p_hd;
		HD_RATE <= 5'h16;
	endproperty
	a_hd: assert property (p_hd)
		else $error("HD rate out of range");
	property p_regen;
		CE && TC_PRESENT && MENU_STATE != 2'd0 |=> TC_REGEN;
	endproperty
	a_regen: assert property (p_regen)
		else $error("no regeneration with code present");
	property p_mtc_off;
		CE && !TC_GENERATING |=> !MTC_ENABLE;
	endproperty
	a_mtc_off: assert property (p_mtc_off)
		else $error("MTC on while not generating");
	property p_mtc_on;
		CE && TC_GENERATING && !LTC_IDLE && MENU_STATE != 2'd0
			|=> MTC_ENABLE;
	endproperty
	a_mtc_on: assert property (p_mtc_on)
		else $error("MTC off while generating");
	property p_edit_in;
		$rose(MENU_STATE == 2'd3) |-> $past(MENU_STATE) == 2'd2;
	endproperty
	a_edit_in: assert property (p_edit_in)
		else $error("edit entered from outside browse");
	property p_edit_out;
		MENU_STATE == 2'd3 |=> MENU_STATE[1];
	endproperty
	a_edit_out: assert property (p_edit_out)
		else $error("edit left to a state other than browse");
	property p_item;
		MENU_ITEM <= 4'he;
	endproperty
	a_item: assert property (p_item)
		else $error("menu item past the last one");
	c_edit: cover property (MENU_STATE == 2'd3);
	c_muted: cover property (TC_GENERATING && !MTC_ENABLE);
	c_refused: cover property (PSLVERR);
endmodule
bind timecode_parameter_menu timecode_menu_checker chk (
	.CLOCK(CLOCK), .RESETN(RESETN), .CE(CE), .TC_PRESENT(TC_PRESENT),
	.TC_GENERATING(TC_GENERATING), .LTC_IDLE(LTC_IDLE),
	.PSLVERR(PSLVERR), .MENU_STATE(MENU_STATE), .MENU_ITEM(MENU_ITEM),
	.TC_REGEN(TC_REGEN), .MTC_ENABLE(MTC_ENABLE),
	.VITC_GEN_LINE(VITC_GEN_LINE), .LTC_LEVEL_DBU(LTC_LEVEL_DBU),
	.RESOLVE_GAIN(RESOLVE_GAIN), .HD_RATE(HD_RATE));

// ### timecode_menu_defs.vh
// Constants for the front-panel parameter menu and its settings store.
`ifndef TIMECODE_MENU_DEFS_VH
`define TIMECODE_MENU_DEFS_VH

// Menu item indices, in front-panel scroll order.
`define ITM_INSVITC   4'h0
`define ITM_RDLINE    4'h1
`define ITM_GENLINE   4'h2
`define ITM_OVERLAY   4'h3
`define ITM_FREEWHL   4'h4
`define ITM_LEVEL     4'h5
`define ITM_GAIN      4'h6
`define ITM_HOLD      4'h7
`define ITM_PPF       4'h8
`define ITM_TACHDIR   4'h9
`define ITM_SDFMT     4'ha
`define ITM_HDRATE    4'hb
`define ITM_IDLEMUTE  4'hc
`define ITM_DEVID     4'hd
`define ITM_LEGACY    4'he
`define ITEM_LAST     4'he

// Items whose committed value is kept in the non-volatile store.
`define NV_MASK       16'h0d8c

// Value ranges and factory defaults.
`define MAX_ONOFF     8'h01
`define MAX_RDLINE    8'h10
`define MIN_GENLINE   8'h0a
`define MAX_GENLINE   8'h14
`define DEF_GENLINE   8'h0e
`define GENLINE_STEP  8'h02
`define MIN_FREEWHL   8'h01
`define MAX_FREEWHL   8'hff
`define DEF_FREEWHL   8'h08
`define MAX_LEVEL     8'h21
`define DEF_LEVEL     8'h1b
`define LEVEL_OFS     8'h18
`define MAX_GAIN      8'h04
`define MIN_PPF       8'h01
`define MAX_PPF       8'hff
`define DEF_PPF       8'h64
`define MAX_TACHDIR   8'h03
`define MAX_HDRATE    8'h16
`define DEF_ON        8'h01
`define DEF_OFF       8'h00

// Menu states.
`define S_RSTCHK      3'h0
`define S_LOADRD      3'h1
`define S_LOADWR      3'h2
`define S_IDLE        3'h3
`define S_BROWSE      3'h4
`define S_EDIT        3'h5

// APB register offsets.
`define OFF_STATUS    12'h000
`define OFF_LINK      12'h004
`define OFF_CFG       12'h040
`define OFF_CFG_LAST  12'h078

`endif

// ### timecode_parameter_menu.v
// Front-panel parameter menu, settings registers and applied settings.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "timecode_menu_defs.vh"
// What this block does
// - Read pair is the chosen one, or in auto the first valid pair.
// - Generate line pair selects insertion lines; default is lines 14/16.
// - Generate, overlay, hold, pulses, SD and HD format survive power loss.
// - The menu only switches the overlay window on or off.
// - Time code keeps regenerating for the freewheel length in frames.
// - Output level spans -24 to +9 dBu and is shown in dBu.
// - Servo gain has five values, 0000 down to -0004, default 0000.
// - Smoothest gain trades slow resolve, six to ten seconds, for low jitter.
// - Rate hold keeps the last known reference rate on off-speed code.
// - Pulses per frame sets tach pulses per time code frame.
// - Tach direction setting says how direction is derived.
// - One NTSC or PAL setting for both video directions, no mismatch warning.
// - HD reference rate has 23 choices for the HD clock reference.
// - MTC runs while generating; idle muting stops it while LTC idles.
// - Identity setting picks native or older sibling identity.
// - Set picks a parameter, shows value; up/down steps; set commits.
// - Factory defaults as listed, applied by holding up and down at reset.
module timecode_parameter_menu (
	// Clock, reset and clock enable.
	input  wire        CLOCK,
	input  wire        RESETN,
	input  wire        CE,
	// Front-panel switches, high while pressed.
	input  wire        SW_SET,
	input  wire        SW_UP,
	input  wire        SW_DOWN,
	input  wire        SW_ESC,
	// APB slave.
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	// Video and time code status.
	input  wire [15:0] VITC_PAIR_VALID,
	input  wire        TC_PRESENT,
	input  wire        FRAME_TICK,
	input  wire        TC_GENERATING,
	input  wire        LTC_IDLE,
	// Menu display.
	output reg  [1:0]  MENU_STATE,
	output reg  [3:0]  MENU_ITEM,
	output reg  [7:0]  DISP_VALUE,
	// Applied settings.
	output reg         VITC_INSERT_EN,
	output reg  [3:0]  VITC_READ_PAIR,
	output reg         VITC_READ_FOUND,
	output reg  [7:0]  VITC_GEN_LINE,
	output reg         OVERLAY_ENABLE,
	output reg         TC_REGEN,
	output reg  [7:0]  FREEWHEEL_LEFT,
	output reg  [7:0]  LTC_LEVEL_DBU,
	output reg  [2:0]  RESOLVE_GAIN,
	output reg         RATE_HOLD,
	output reg  [7:0]  TACH_PPF,
	output reg  [1:0]  TACH_DIRECTION,
	output reg         SD_FORMAT_PAL,
	output reg  [4:0]  HD_RATE,
	output reg         MTC_ENABLE,
	output reg         SIBLING_IDENTITY,
	output reg         LEGACY_EMULATION
);

////////////////////////////////////////////////////////////////////////////////

function [7:0] item_min;
	input [3:0] i;
	begin
		case (i)
			`ITM_GENLINE: item_min = `MIN_GENLINE;
			`ITM_FREEWHL: item_min = `MIN_FREEWHL;
			`ITM_PPF:     item_min = `MIN_PPF;
			default:      item_min = 8'h00;
		endcase
	end
endfunction

function [7:0] item_max;
	input [3:0] i;
	begin
		case (i)
			`ITM_RDLINE:  item_max = `MAX_RDLINE;
			`ITM_GENLINE: item_max = `MAX_GENLINE;
			`ITM_FREEWHL: item_max = `MAX_FREEWHL;
			`ITM_LEVEL:   item_max = `MAX_LEVEL;
			`ITM_GAIN:    item_max = `MAX_GAIN;
			`ITM_PPF:     item_max = `MAX_PPF;
			`ITM_TACHDIR: item_max = `MAX_TACHDIR;
			`ITM_HDRATE:  item_max = `MAX_HDRATE;
			default:      item_max = `MAX_ONOFF;
		endcase
	end
endfunction

function [7:0] item_def;
	input [3:0] i;
	begin
		case (i)
			`ITM_INSVITC:  item_def = `DEF_ON;
			`ITM_GENLINE:  item_def = `DEF_GENLINE;
			`ITM_OVERLAY:  item_def = `DEF_ON;
			`ITM_FREEWHL:  item_def = `DEF_FREEWHL;
			`ITM_LEVEL:    item_def = `DEF_LEVEL;
			`ITM_PPF:      item_def = `DEF_PPF;
			`ITM_IDLEMUTE: item_def = `DEF_ON;
			default:       item_def = `DEF_OFF;
		endcase
	end
endfunction

// Generate lines step by whole pairs; every other list steps by one.
function [7:0] item_step;
	input [3:0] i;
	begin
		item_step = (i == `ITM_GENLINE) ? `GENLINE_STEP : 8'h01;
	end
endfunction

// Level shows in dBu and gain as zero or negative.
function [7:0] disp_of;
	input [3:0] i;
	input [7:0] v;
	begin
		case (i)
			`ITM_LEVEL: disp_of = v - `LEVEL_OFS;
			`ITM_GAIN:  disp_of = 8'h00 - v;
			default:    disp_of = v;
		endcase
	end
endfunction

function in_range;
	input [3:0] i;
	input [7:0] v;
	begin
		// Generate lines take only the first line of a pair, so even codes.
		in_range = (v >= item_min(i)) && (v <= item_max(i)) &&
			((i != `ITM_GENLINE) || !v[0]);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////

reg  [7:0]  cfg_reg [0:15];
reg  [2:0]  state_reg;
reg  [3:0]  item_reg;
reg  [7:0]  edit_reg;
reg         factory_reg;
reg         set_prev_reg;
reg         up_prev_reg;
reg         down_prev_reg;
reg         esc_prev_reg;
reg         mem_we_reg;
reg  [3:0]  mem_waddr_reg;
reg  [7:0]  mem_wdata_reg;
reg  [7:0]  fw_cnt_reg;
wire [7:0]  mem_rdata;
wire [7:0]  cur_val;
wire        set_p;
wire        up_p;
wire        down_p;
wire        esc_p;
wire        menu_commit;
wire        apb_go;
wire        cfg_hit;
wire [3:0]  widx;
wire        wr_ok;
reg  [3:0]  scan_idx;
reg         scan_hit;
reg  [31:0] rd_next;
reg         err_next;
integer     k;
integer     j;
wire [11:0] cfg_ofs;

localparam [15:0] nv_items = `NV_MASK;

assign set_p = SW_SET & ~set_prev_reg;
assign up_p = SW_UP & ~up_prev_reg;
assign down_p = SW_DOWN & ~down_prev_reg;
assign esc_p = SW_ESC & ~esc_prev_reg;
assign cur_val = cfg_reg[item_reg];
assign menu_commit = (state_reg == `S_EDIT) && set_p;

// A bus access waits while the settings load or a panel commit is taken.
assign apb_go = PSEL && PENABLE && !PREADY && !menu_commit &&
	(state_reg >= `S_IDLE);
assign cfg_hit = (PADDR >= `OFF_CFG) && (PADDR <= `OFF_CFG_LAST) &&
	(PADDR[1:0] == 2'b00);
assign cfg_ofs = PADDR - `OFF_CFG;
assign widx = cfg_ofs[5:2];
assign wr_ok = cfg_hit && (PWDATA[31:8] == 24'h000000) &&
	in_range(widx, PWDATA[7:0]);

settings_store #(
	.AW(4),
	.DW(8)
) u_store (
	.clk  (CLOCK),
	.rst_n(RESETN),
	.ce   (CE),
	.we   (mem_we_reg),
	.waddr(mem_waddr_reg),
	.wdata(mem_wdata_reg),
	.raddr(item_reg),
	.rdata(mem_rdata)
);

////////////////////////////////////////////////////////////////////////////////

// Lowest valid pair wins the automatic scan.
always @* begin
	scan_hit = 1'b0;
	scan_idx = 4'h0;
	for (k = 15; k >= 0; k = k - 1) begin
		if (VITC_PAIR_VALID[k]) begin
			scan_hit = 1'b1;
			scan_idx = k[3:0];
		end
	end
end

always @* begin
	rd_next = 32'h00000000;
	err_next = 1'b0;
	if (PADDR == `OFF_STATUS) begin
		rd_next = {16'h0000, factory_reg, 1'b0, MENU_STATE, item_reg,
			edit_reg};
		err_next = PWRITE;
	end else if (PADDR == `OFF_LINK) begin
		rd_next = {16'h0000, TC_REGEN, VITC_READ_FOUND, MTC_ENABLE, 1'b0,
			VITC_READ_PAIR, FREEWHEEL_LEFT};
		err_next = PWRITE;
	end else if (cfg_hit && widx <= `ITEM_LAST) begin
		rd_next = {24'h000000, cfg_reg[widx]};
		err_next = PWRITE && !wr_ok;
	end else begin
		err_next = 1'b1;
	end
end

always @(posedge CLOCK or negedge RESETN) begin
	if (!RESETN) begin
		PRDATA <= 32'h00000000;
		PREADY <= 1'b0;
		PSLVERR <= 1'b0;
	end else if (CE) begin
		PREADY <= apb_go;
		PSLVERR <= apb_go && err_next;
		if (apb_go && !PWRITE) begin
			PRDATA <= rd_next;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge CLOCK or negedge RESETN) begin
	if (!RESETN) begin
		state_reg <= `S_RSTCHK;
		item_reg <= 4'h0;
		edit_reg <= 8'h00;
		factory_reg <= 1'b0;
		set_prev_reg <= 1'b0;
		up_prev_reg <= 1'b0;
		down_prev_reg <= 1'b0;
		esc_prev_reg <= 1'b0;
		mem_we_reg <= 1'b0;
		mem_waddr_reg <= 4'h0;
		mem_wdata_reg <= 8'h00;
		for (j = 0; j < 16; j = j + 1) begin
			cfg_reg[j] <= 8'h00;
		end
	end else if (CE) begin
		set_prev_reg <= SW_SET;
		up_prev_reg <= SW_UP;
		down_prev_reg <= SW_DOWN;
		esc_prev_reg <= SW_ESC;
		mem_we_reg <= 1'b0;
		case (state_reg)
			`S_RSTCHK: begin
				factory_reg <= SW_UP & SW_DOWN;
				item_reg <= 4'h0;
				state_reg <= `S_LOADRD;
			end
			`S_LOADRD: begin
				state_reg <= `S_LOADWR;
			end
			`S_LOADWR: begin
				if (factory_reg || !nv_items[item_reg] ||
					!in_range(item_reg, mem_rdata)) begin
					cfg_reg[item_reg] <= item_def(item_reg);
					mem_we_reg <= nv_items[item_reg];
					mem_waddr_reg <= item_reg;
					mem_wdata_reg <= item_def(item_reg);
				end else begin
					cfg_reg[item_reg] <= mem_rdata;
				end
				if (item_reg == `ITEM_LAST) begin
					item_reg <= 4'h0;
					state_reg <= `S_IDLE;
				end else begin
					item_reg <= item_reg + 4'h1;
					state_reg <= `S_LOADRD;
				end
			end
			`S_IDLE: begin
				if (set_p) begin
					state_reg <= `S_BROWSE;
				end
			end
			`S_BROWSE: begin
				if (set_p) begin
					edit_reg <= cur_val;
					state_reg <= `S_EDIT;
				end else if (esc_p) begin
					state_reg <= `S_IDLE;
				end else if (up_p) begin
					item_reg <= (item_reg == `ITEM_LAST) ? 4'h0 :
						item_reg + 4'h1;
				end else if (down_p) begin
					item_reg <= (item_reg == 4'h0) ? `ITEM_LAST :
						item_reg - 4'h1;
				end
			end
			`S_EDIT: begin
				if (set_p) begin
					cfg_reg[item_reg] <= edit_reg;
					mem_we_reg <= nv_items[item_reg];
					mem_waddr_reg <= item_reg;
					mem_wdata_reg <= edit_reg;
					state_reg <= `S_BROWSE;
				end else if (esc_p) begin
					state_reg <= `S_BROWSE;
				end else if (up_p) begin
					edit_reg <= (edit_reg >= item_max(item_reg)) ?
						item_min(item_reg) :
						edit_reg + item_step(item_reg);
				end else if (down_p) begin
					edit_reg <= (edit_reg <= item_min(item_reg)) ?
						item_max(item_reg) :
						edit_reg - item_step(item_reg);
				end
			end
			default: begin
				state_reg <= `S_IDLE;
			end
		endcase
		if (apb_go && PWRITE && wr_ok) begin
			cfg_reg[widx] <= PWDATA[7:0];
			mem_we_reg <= nv_items[widx];
			mem_waddr_reg <= widx;
			mem_wdata_reg <= PWDATA[7:0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge CLOCK or negedge RESETN) begin
	if (!RESETN) begin
		fw_cnt_reg <= 8'h00;
	end else if (CE) begin
		if (TC_PRESENT) begin
			fw_cnt_reg <= cfg_reg[`ITM_FREEWHL];
		end else if (FRAME_TICK && fw_cnt_reg != 8'h00) begin
			fw_cnt_reg <= fw_cnt_reg - 8'h01;
		end
	end
end

always @(posedge CLOCK or negedge RESETN) begin
	if (!RESETN) begin
		MENU_STATE <= 2'h0;
		MENU_ITEM <= 4'h0;
		DISP_VALUE <= 8'h00;
		VITC_INSERT_EN <= 1'b0;
		VITC_READ_PAIR <= 4'h0;
		VITC_READ_FOUND <= 1'b0;
		VITC_GEN_LINE <= 8'h00;
		OVERLAY_ENABLE <= 1'b0;
		TC_REGEN <= 1'b0;
		FREEWHEEL_LEFT <= 8'h00;
		LTC_LEVEL_DBU <= 8'h00;
		RESOLVE_GAIN <= 3'h0;
		RATE_HOLD <= 1'b0;
		TACH_PPF <= 8'h00;
		TACH_DIRECTION <= 2'h0;
		SD_FORMAT_PAL <= 1'b0;
		HD_RATE <= 5'h00;
		MTC_ENABLE <= 1'b0;
		SIBLING_IDENTITY <= 1'b0;
		LEGACY_EMULATION <= 1'b0;
	end else if (CE) begin
		MENU_STATE <= (state_reg == `S_EDIT) ? 2'h3 :
			(state_reg == `S_BROWSE) ? 2'h2 :
			(state_reg == `S_IDLE) ? 2'h1 : 2'h0;
		MENU_ITEM <= item_reg;
		DISP_VALUE <= disp_of(item_reg,
			(state_reg == `S_EDIT) ? edit_reg : cur_val);
		VITC_INSERT_EN <= cfg_reg[`ITM_INSVITC][0];
		if (cfg_reg[`ITM_RDLINE] == 8'h00) begin
			VITC_READ_PAIR <= scan_idx;
			VITC_READ_FOUND <= scan_hit;
		end else begin
			VITC_READ_PAIR <= cfg_reg[`ITM_RDLINE][3:0] - 4'h1;
			VITC_READ_FOUND <= 1'b1;
		end
		VITC_GEN_LINE <= cfg_reg[`ITM_GENLINE];
		OVERLAY_ENABLE <= cfg_reg[`ITM_OVERLAY][0];
		TC_REGEN <= TC_PRESENT || (fw_cnt_reg != 8'h00);
		FREEWHEEL_LEFT <= fw_cnt_reg;
		LTC_LEVEL_DBU <= cfg_reg[`ITM_LEVEL] - `LEVEL_OFS;
		RESOLVE_GAIN <= cfg_reg[`ITM_GAIN][2:0];
		RATE_HOLD <= cfg_reg[`ITM_HOLD][0];
		TACH_PPF <= cfg_reg[`ITM_PPF];
		TACH_DIRECTION <= cfg_reg[`ITM_TACHDIR][1:0];
		SD_FORMAT_PAL <= cfg_reg[`ITM_SDFMT][0];
		HD_RATE <= cfg_reg[`ITM_HDRATE][4:0];
		MTC_ENABLE <= TC_GENERATING &&
			!(cfg_reg[`ITM_IDLEMUTE][0] && LTC_IDLE);
		SIBLING_IDENTITY <= cfg_reg[`ITM_DEVID][0];
		LEGACY_EMULATION <= cfg_reg[`ITM_LEGACY][0];
	end
end

endmodule
